//--- atdb_top.v
// Top of the trigger delay block: Wishbone registers, trigger select, counter and two channels.
//
// The address map and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "atdb_regs.vh"

module atdb_top (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        ext_trigger_i,
  input  wire        comparator1_i,
  input  wire        comparator2_i,
  input  wire [1:0]  conversion_complete_flag_a_i,
  input  wire [1:0]  conversion_complete_flag_b_i,
  output wire [1:0]  preselect_set_a_o,
  output wire [1:0]  preselect_set_b_o,
  output wire [1:0]  convert_pulse_a_o,
  output wire [1:0]  convert_pulse_b_o,
  output reg         interval_irq_o,
  output reg         error_irq_o
);

  reg  [7:0]  ctrl;
  reg  [15:0] modulus;
  reg  [15:0] idelay;
  reg  [15:0] dly [0:3];
  reg  [3:0]  err_en;
  reg  [4:0]  flags;
  reg  [15:0] count;
  reg         running;
  reg         sw_go;
  reg  [2:0]  pin_s1;
  reg  [2:0]  pin_s2;
  reg  [2:0]  pin_s3;
  reg         trig_edge;

  wire        wb_req;
  wire        wb_wr;
  wire [15:0] wr_val;
  wire [15:0] wr_ctrl;
  wire        tick;
  wire        cnt_tick;
  wire        go;
  wire [2:0]  pin_rise;
  wire [3:0]  fire;
  wire [3:0]  fault;
  wire [1:0]  sel;
  wire        enable;
  wire        one_shot;

  // Merges the enabled byte lanes of the write data into a 16-bit register.
  function [15:0] atdb_merge;
    input [15:0] old;
    input [31:0] dat;
    input [3:0]  lanes;
    begin
      atdb_merge = {lanes[1] ? dat[15:8] : old[15:8], lanes[0] ? dat[7:0] : old[7:0]};
    end
  endfunction

  // Reads back a delay or limit word in the low half of the bus.
  function [31:0] atdb_word;
    input [15:0] val;
    begin
      atdb_word = {16'h0000, val};
    end
  endfunction

  assign wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr    = wb_req && wb_we_i;
  assign wr_val   = atdb_merge(16'h0000, wb_dat_i, wb_sel_i);
  assign wr_ctrl  = atdb_merge({8'h00, ctrl}, wb_dat_i, wb_sel_i);

  assign sel      = ctrl[`ATDB_CTRL_SEL_MSB:`ATDB_CTRL_SEL_LSB];
  assign enable   = ctrl[`ATDB_CTRL_ENABLE];
  assign one_shot = ctrl[`ATDB_CTRL_ONESHOT];

  // Wishbone classic slave: one wait state, ack for one cycle, unmapped reads zero.
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `ATDB_OFF_CTRL:    wb_dat_o <= {24'h000000, ctrl};
          `ATDB_OFF_MOD:     wb_dat_o <= atdb_word(modulus);
          `ATDB_OFF_IDELAY:  wb_dat_o <= atdb_word(idelay);
          `ATDB_OFF_C1_DLYA: wb_dat_o <= atdb_word(dly[0]);
          `ATDB_OFF_C1_DLYB: wb_dat_o <= atdb_word(dly[1]);
          `ATDB_OFF_C2_DLYA: wb_dat_o <= atdb_word(dly[2]);
          `ATDB_OFF_C2_DLYB: wb_dat_o <= atdb_word(dly[3]);
          `ATDB_OFF_ERR_EN:  wb_dat_o <= {28'h0000000, err_en};
          `ATDB_OFF_STATUS:  wb_dat_o <= {26'h0, running, flags};
          `ATDB_OFF_COUNT:   wb_dat_o <= atdb_word(count);
          default:           wb_dat_o <= 32'h00000000;
        endcase
      end else begin
        wb_dat_o <= 32'h00000000;
      end
    end
  end

  // Configuration registers written by software.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl    <= `ATDB_CTRL_RST;
      modulus <= `ATDB_MOD_RST;
      idelay  <= `ATDB_IDELAY_RST;
      dly[0]  <= `ATDB_DLY_RST;
      dly[1]  <= `ATDB_DLY_RST;
      dly[2]  <= `ATDB_DLY_RST;
      dly[3]  <= `ATDB_DLY_RST;
      err_en  <= `ATDB_ERR_EN_RST;
      sw_go   <= 1'b0;
    end else begin
      sw_go <= 1'b0;
      if (wb_wr) begin
        case (wb_adr_i)
          `ATDB_OFF_CTRL: begin
            ctrl  <= wr_ctrl[7:0];
            sw_go <= wr_ctrl[`ATDB_CTRL_SWTRIG] && (sel == `ATDB_SEL_SW);
          end
          `ATDB_OFF_MOD: begin
            modulus <= atdb_merge(modulus, wb_dat_i, wb_sel_i);
          end
          `ATDB_OFF_IDELAY: begin
            idelay <= atdb_merge(idelay, wb_dat_i, wb_sel_i);
          end
          `ATDB_OFF_C1_DLYA: begin
            dly[0] <= atdb_merge(dly[0], wb_dat_i, wb_sel_i);
          end
          `ATDB_OFF_C1_DLYB: begin
            dly[1] <= atdb_merge(dly[1], wb_dat_i, wb_sel_i);
          end
          `ATDB_OFF_C2_DLYA: begin
            dly[2] <= atdb_merge(dly[2], wb_dat_i, wb_sel_i);
          end
          `ATDB_OFF_C2_DLYB: begin
            dly[3] <= atdb_merge(dly[3], wb_dat_i, wb_sel_i);
          end
          `ATDB_OFF_ERR_EN: begin
            if (wb_sel_i[0]) begin
              err_en <= wb_dat_i[3:0];
            end
          end
          default: begin
            sw_go <= 1'b0;
          end
        endcase
      end
    end
  end

  // Two-stage synchronisers for the pin and comparator inputs.
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gen_sync
      always @(posedge clk_i) begin
        if (rst_i) begin
          pin_s1[g] <= 1'b0;
          pin_s2[g] <= 1'b0;
          pin_s3[g] <= 1'b0;
        end else begin
          pin_s1[g] <= (g == 0) ? ext_trigger_i : ((g == 1) ? comparator1_i : comparator2_i);
          pin_s2[g] <= pin_s1[g];
          pin_s3[g] <= pin_s2[g];
        end
      end
      assign pin_rise[g] = pin_s2[g] && !pin_s3[g];
    end
  endgenerate

  // The selected source is reduced to a single rising-edge event.
  always @* begin
    case (sel)
      `ATDB_SEL_EXT:  trig_edge = pin_rise[0];
      `ATDB_SEL_SW:   trig_edge = sw_go;
      `ATDB_SEL_CMP1: trig_edge = pin_rise[1];
      `ATDB_SEL_CMP2: trig_edge = pin_rise[2];
      default:        trig_edge = 1'b0;
    endcase
  end

  assign go       = enable && trig_edge;
  assign cnt_tick = running && tick;

  atdb_prescaler u_prescaler (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .clear_i (go),
    .sel_i   (ctrl[`ATDB_CTRL_PS_MSB:`ATDB_CTRL_PS_LSB]),
    .tick_o  (tick)
  );

  // Delay counter: a trigger restarts it from zero, the modulus ends each period.
  always @(posedge clk_i) begin
    if (rst_i) begin
      count   <= 16'h0000;
      running <= 1'b0;
    end else if (!enable) begin
      count   <= 16'h0000;
      running <= 1'b0;
    end else if (go) begin
      count   <= 16'h0000;
      running <= 1'b1;
    end else if (cnt_tick) begin
      if (count == modulus) begin
        if (one_shot) begin
          running <= 1'b0;
        end else begin
          count <= 16'h0000;
        end
      end else begin
        count <= count + 16'h0001;
      end
    end
  end

  // Each delay register fires its channel input once per period when the counter matches; a fire the channel refuses raises a sequence fault.
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_match
      assign fire[g] = cnt_tick && (count == dly[g]);
    end
    for (g = 0; g < 2; g = g + 1) begin : gen_chan
      atdb_channel u_channel (
        .clk_i              (clk_i),
        .rst_i              (rst_i),
        .fire_a_i           (fire[2*g]),
        .fire_b_i           (fire[2*g+1]),
        .done_a_i           (conversion_complete_flag_a_i[g]),
        .done_b_i           (conversion_complete_flag_b_i[g]),
        .preselect_set_a_o  (preselect_set_a_o[g]),
        .preselect_set_b_o  (preselect_set_b_o[g]),
        .convert_pulse_a_o  (convert_pulse_a_o[g]),
        .convert_pulse_b_o  (convert_pulse_b_o[g]),
        .sequence_fault_a_o (fault[2*g]),
        .sequence_fault_b_o (fault[2*g+1])
      );
    end
  endgenerate

  // Sticky event flags are cleared by writing one; a new event wins over the clear.
  always @(posedge clk_i) begin
    if (rst_i) begin
      flags <= 5'h00;
    end else begin
      if (wb_wr && wb_adr_i == `ATDB_OFF_STATUS) begin
        flags <= (flags & ~wr_val[4:0]) | {fault, cnt_tick && (count == idelay)};
      end else begin
        flags <= flags | {fault, cnt_tick && (count == idelay)};
      end
    end
  end

  // Interrupt requests are the flags gated by their enables.
  always @(posedge clk_i) begin
    if (rst_i) begin
      interval_irq_o <= 1'b0;
      error_irq_o    <= 1'b0;
    end else begin
      interval_irq_o <= flags[`ATDB_ST_IDELAY] && ctrl[`ATDB_CTRL_IDLY_IE];
      error_irq_o    <= |(flags[`ATDB_ST_FAULT_MSB:`ATDB_ST_FAULT_LSB] & err_en);
    end
  end

endmodule
`default_nettype wire

//--- atdb_regs.vh
// Register offsets, field positions, reset values and timing counts of the trigger delay block.
`ifndef ATDB_REGS_VH
`define ATDB_REGS_VH

`define ATDB_OFF_CTRL     8'h00
`define ATDB_OFF_MOD      8'h04
`define ATDB_OFF_IDELAY   8'h08
`define ATDB_OFF_C1_DLYA  8'h0C
`define ATDB_OFF_C1_DLYB  8'h10
`define ATDB_OFF_C2_DLYA  8'h14
`define ATDB_OFF_C2_DLYB  8'h18
`define ATDB_OFF_ERR_EN   8'h1C
`define ATDB_OFF_STATUS   8'h20
`define ATDB_OFF_COUNT    8'h24

`define ATDB_CTRL_PS_LSB  0
`define ATDB_CTRL_PS_MSB  2
`define ATDB_CTRL_ONESHOT 3
`define ATDB_CTRL_SEL_LSB 4
`define ATDB_CTRL_SEL_MSB 5
`define ATDB_CTRL_IDLY_IE 6
`define ATDB_CTRL_ENABLE  7
`define ATDB_CTRL_SWTRIG  8

`define ATDB_SEL_EXT      2'h0
`define ATDB_SEL_SW       2'h1
`define ATDB_SEL_CMP1     2'h2
`define ATDB_SEL_CMP2     2'h3

`define ATDB_ST_IDELAY    0
`define ATDB_ST_FAULT_LSB 1
`define ATDB_ST_FAULT_MSB 4
`define ATDB_ST_RUNNING   5

`define ATDB_CTRL_RST     8'h00
`define ATDB_MOD_RST      16'hFFFF
`define ATDB_IDELAY_RST   16'hFFFF
`define ATDB_DLY_RST      16'h0000
`define ATDB_ERR_EN_RST   4'h0

`define ATDB_PRE_LEAD     2

`endif

//--- atdb_prescaler.v
// Power-of-two clock prescaler that issues one tick per divided period.
`timescale 1ns/1ps
`default_nettype none
`include "atdb_regs.vh"

module atdb_prescaler (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       clear_i,
  input  wire [2:0] sel_i,
  output wire       tick_o
);

  reg  [6:0] count;
  wire [6:0] limit;

  // The limit is two to the power sel minus one.
  assign limit  = 7'h7F >> (3'h7 - sel_i);
  assign tick_o = (count == limit);

  always @(posedge clk_i) begin
    if (rst_i || clear_i || tick_o) begin
      count <= 7'h00;
    end else begin
      count <= count + 7'h01;
    end
  end

endmodule
`default_nettype wire

//--- atdb_channel.v
// One output channel: pre-select and convert pulses for sets A and B with sequence fault detection.
`timescale 1ns/1ps
`default_nettype none
`include "atdb_regs.vh"

module atdb_channel (
  input  wire clk_i,
  input  wire rst_i,
  input  wire fire_a_i,
  input  wire fire_b_i,
  input  wire done_a_i,
  input  wire done_b_i,
  output reg  preselect_set_a_o,
  output reg  preselect_set_b_o,
  output wire convert_pulse_a_o,
  output wire convert_pulse_b_o,
  output reg  sequence_fault_a_o,
  output reg  sequence_fault_b_o
);

  reg  [`ATDB_PRE_LEAD:0] pipe_a;
  reg  [`ATDB_PRE_LEAD:0] pipe_b;
  reg                     busy_a;
  reg                     busy_b;
  wire                    take_a;
  wire                    take_b;

  // A fires only while no B conversion is pending; B yields to A in the same cycle.
  assign take_a = fire_a_i && !busy_b;
  assign take_b = fire_b_i && !busy_a && !take_a;

  // The convert pulse leaves the pipe two cycles after the pre-select rises.
  assign convert_pulse_a_o = pipe_a[`ATDB_PRE_LEAD];
  assign convert_pulse_b_o = pipe_b[`ATDB_PRE_LEAD];

  always @(posedge clk_i) begin
    if (rst_i) begin
      pipe_a             <= 3'h0;
      pipe_b             <= 3'h0;
      busy_a             <= 1'b0;
      busy_b             <= 1'b0;
      preselect_set_a_o  <= 1'b0;
      preselect_set_b_o  <= 1'b0;
      sequence_fault_a_o <= 1'b0;
      sequence_fault_b_o <= 1'b0;
    end else begin
      pipe_a             <= {pipe_a[`ATDB_PRE_LEAD-1:0], take_a};
      pipe_b             <= {pipe_b[`ATDB_PRE_LEAD-1:0], take_b};
      preselect_set_a_o  <= take_a | (|pipe_a[`ATDB_PRE_LEAD-1:0]);
      preselect_set_b_o  <= take_b | (|pipe_b[`ATDB_PRE_LEAD-1:0]);
      sequence_fault_a_o <= fire_a_i && !take_a;
      sequence_fault_b_o <= fire_b_i && !take_b;
      // Busy holds from acceptance until the completion flag follows the convert pulse.
      if (take_a) begin
        busy_a <= 1'b1;
      end else if (done_a_i && pipe_a == 3'h0) begin
        busy_a <= 1'b0;
      end
      if (take_b) begin
        busy_b <= 1'b1;
      end else if (done_b_i && pipe_b == 3'h0) begin
        busy_b <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

//--- atdb_sva.sv
// Checker of bus handshake and output pulse timing for the trigger delay block.
`timescale 1ns/1ps
`default_nettype none
module atdb_sva (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic [1:0]  conversion_complete_flag_a_i,
  input wire logic [1:0]  preselect_set_a_o,
  input wire logic [1:0]  preselect_set_b_o,
  input wire logic [1:0]  convert_pulse_a_o,
  input wire logic [1:0]  convert_pulse_b_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_one_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data not zero");
  chk_lead_a0: assert property (convert_pulse_a_o[0] |-> $past(preselect_set_a_o[0], 2) && !$past(preselect_set_a_o[0], 3))
    else $error("preselect a lead wrong");
  chk_lead_b0: assert property (convert_pulse_b_o[0] |-> $past(preselect_set_b_o[0], 2) && !$past(preselect_set_b_o[0], 3))
    else $error("preselect b lead wrong");
  chk_lead_a1: assert property (convert_pulse_a_o[1] |-> preselect_set_a_o[1] && $past(preselect_set_a_o[1], 2))
    else $error("channel two lead wrong");
  chk_lead_b1: assert property (convert_pulse_b_o[1] |-> $past(preselect_set_b_o[1], 2) && !$past(preselect_set_b_o[1], 3))
    else $error("channel two b lead wrong");
  chk_conv_single: assert property (convert_pulse_a_o != 2'h0 |=> (convert_pulse_a_o & $past(convert_pulse_a_o)) == 2'h0)
    else $error("convert pulse too long");
  chk_no_overlap: assert property ((convert_pulse_a_o & convert_pulse_b_o) == 2'h0)
    else $error("convert a and b together");
  chk_b_waits_a: assert property (convert_pulse_a_o[0] |=> !convert_pulse_b_o[0] until conversion_complete_flag_a_i[0])
    else $error("convert b while a busy");
endmodule
bind atdb_top atdb_sva i_atdb_sva (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o),
  .wb_dat_o(wb_dat_o),
  .conversion_complete_flag_a_i(conversion_complete_flag_a_i),
  .preselect_set_a_o(preselect_set_a_o),
  .preselect_set_b_o(preselect_set_b_o),
  .convert_pulse_a_o(convert_pulse_a_o),
  .convert_pulse_b_o(convert_pulse_b_o)
);
`default_nettype wire

//--- atdb_adc_model.sv
// Converter model: answers each convert pulse with a one-cycle completion after a set latency.
`timescale 1ns/1ps
`default_nettype none
module atdb_adc_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] lat_i,
  input  wire logic [3:0] conv_i,
  output var  logic [3:0] done_o
);
  logic [7:0] cnt [4];
  always @(posedge clk_i) begin
    for (int k = 0; k < 4; k++) begin
      done_o[k] <= 1'b0;
      if (rst_i) begin
        cnt[k] <= 8'h00;
      end else if (conv_i[k]) begin
        cnt[k] <= lat_i;
      end else if (cnt[k] == 8'h01) begin
        cnt[k] <= 8'h00;
        done_o[k] <= 1'b1;
      end else if (cnt[k] != 8'h00) begin
        cnt[k] <= cnt[k] - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

//--- atdb_top_tb.sv
// Self-checking bench of the trigger delay block with a converter model.
`timescale 1ns/1ps
`default_nettype none
`include "atdb_regs.vh"
module atdb_top_tb;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic        ext_trigger_i, comparator1_i, comparator2_i, interval_irq_o, error_irq_o;
  logic [7:0]  wb_adr_i, lat;
  logic [3:0]  wb_sel_i, done;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [1:0]  pa, pb, ca, cb;
  int          n_fail, n_compared, nc [4];
  wire logic [3:0] conv;
  assign conv = {cb, ca};
  atdb_top i_atdb_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ext_trigger_i(ext_trigger_i), .comparator1_i(comparator1_i), .comparator2_i(comparator2_i),
    .conversion_complete_flag_a_i(done[1:0]), .conversion_complete_flag_b_i(done[3:2]),
    .preselect_set_a_o(pa), .preselect_set_b_o(pb), .convert_pulse_a_o(ca), .convert_pulse_b_o(cb),
    .interval_irq_o(interval_irq_o), .error_irq_o(error_irq_o));
  atdb_adc_model i_atdb_adc_model (.clk_i(clk_i), .rst_i(rst_i), .lat_i(lat), .conv_i({cb, ca}), .done_o(done));
  always @(posedge clk_i) begin
    for (int k = 0; k < 4; k++) nc[k] <= nc[k] + conv[k];
  end
  task automatic close_out;
    if (n_fail == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) chk(32'h0, 32'h1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic cfg(input logic [15:0] m, i, a1, b1, a2, b2);
    wr(`ATDB_OFF_CTRL, 32'h0);
    wr(`ATDB_OFF_MOD, {16'h0, m});
    wr(`ATDB_OFF_IDELAY, {16'h0, i});
    wr(`ATDB_OFF_C1_DLYA, {16'h0, a1});
    wr(`ATDB_OFF_C1_DLYB, {16'h0, b1});
    wr(`ATDB_OFF_C2_DLYA, {16'h0, a2});
    wr(`ATDB_OFF_C2_DLYB, {16'h0, b2});
  endtask
  task automatic fire(input int k, input logic [31:0] c);
    if (k == 1) wr(`ATDB_OFF_CTRL, c | 32'h100);
    else begin
      @(posedge clk_i);
      ext_trigger_i <= (k == 0);
      comparator1_i <= (k == 2);
      comparator2_i <= (k == 3);
      repeat (4) @(posedge clk_i);
      {ext_trigger_i, comparator1_i, comparator2_i} <= 3'h0;
    end
  endtask
  task automatic wait_pre(output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pa[0] !== 1'b1 && n < 600);
  endtask
  task automatic t_regs;
    logic [7:0] a [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h1C, 8'h20, 8'h30};
    logic [31:0] e [7] = '{32'h0, 32'hFFFF, 32'hFFFF, 32'h0, 32'h0, 32'h0, 32'h0};
    for (int k = 0; k < 7; k++) rd(a[k], e[k]);
    wr(`ATDB_OFF_COUNT, 32'h1234);
    wr(8'h30, 32'h55);
    rd(`ATDB_OFF_COUNT, 32'h0);
    rd(8'h30, 32'h0);
  endtask
  task automatic t_prescale;
    int n, n0;
    cfg(16'h0400, 16'hFFFF, 16'h0002, 16'hFFFF, 16'hFFFF, 16'hFFFF);
    for (int ps = 0; ps < 8; ps++) begin
      wr(`ATDB_OFF_CTRL, 32'h98 | ps);
      fire(1, 32'h98 | ps);
      wait_pre(n);
      if (ps == 0) n0 = n;
      chk(n - n0, (3 << ps) - 3);
      wr(`ATDB_OFF_CTRL, 32'h0);
    end
  endtask
  task automatic t_src;
    int n;
    cfg(16'h0008, 16'hFFFF, 16'h0001, 16'hFFFF, 16'hFFFF, 16'hFFFF);
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < 4; k++) begin
        wr(`ATDB_OFF_CTRL, 32'h88 | (s << 4));
        fire(k, 32'h88 | (s << 4));
        wait_pre(n);
        chk(n < 600, s == k);
        repeat (40) @(posedge clk_i);
      end
    end
  endtask
  task automatic t_fault(input logic [7:0] l, input logic [31:0] st);
    int b0, a1;
    lat <= l;
    cfg(16'h0010, 16'hFFFF, 16'h0002, 16'h0008, 16'h0008, 16'h0002);
    wr(`ATDB_OFF_ERR_EN, 32'h0);
    b0 = nc[2];
    a1 = nc[1];
    wr(`ATDB_OFF_CTRL, 32'h98);
    fire(1, 32'h98);
    repeat (70) @(posedge clk_i);
    rd(`ATDB_OFF_STATUS, st);
    chk(nc[2] - b0, st == 0);
    chk(nc[1] - a1, st == 0);
    chk(error_irq_o, 0);
    wr(`ATDB_OFF_ERR_EN, 32'h6);
    @(posedge clk_i);
    chk(error_irq_o, st != 0);
    wr(`ATDB_OFF_STATUS, 32'h1E);
    @(posedge clk_i);
    chk(error_irq_o, 0);
  endtask
  task automatic t_int;
    int k;
    lat <= 8'h01;
    cfg(16'h0005, 16'h0003, 16'h0002, 16'hFFFF, 16'hFFFF, 16'hFFFF);
    wr(`ATDB_OFF_CTRL, 32'h90);
    fire(1, 32'h90);
    repeat (20) @(posedge clk_i);
    k = nc[0];
    repeat (60) @(posedge clk_i);
    chk(nc[0] - k, 10);
    rd(`ATDB_OFF_STATUS, 32'h21);
    chk(interval_irq_o, 0);
    wr(`ATDB_OFF_CTRL, 32'hD0);
    @(posedge clk_i);
    chk(interval_irq_o, 1);
    wr(`ATDB_OFF_CTRL, 32'h98);
    fire(1, 32'h98);
    repeat (20) @(posedge clk_i);
    k = nc[0];
    repeat (60) @(posedge clk_i);
    chk(nc[0] - k, 0);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, ext_trigger_i, comparator1_i, comparator2_i} = 7'h40;
    {wb_adr_i, wb_sel_i, wb_dat_i, lat} = {8'h0, 4'h0, 32'h0, 8'h01};
    {n_fail, n_compared} = 0;
    for (int k = 0; k < 4; k++) nc[k] = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_prescale;
    t_src;
    t_fault(8'h01, 32'h0);
    t_fault(8'h28, 32'h0C);
    t_int;
    close_out;
  end
  initial begin
    #1000000;
    n_fail++;
    close_out;
  end
endmodule
`default_nettype wire
